//--- pse_regs.sv
// The AXI4-Lite register port was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "pse_defines.svh"
module pse_regs
    import pse_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [15:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [15:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp
);
    // write channel holding registers
    logic aw_full_reg;
    logic w_full_reg;
    logic [15:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic wr_fire;

    // read channel holding registers
    logic ar_full_reg;
    logic [15:0] araddr_reg;
    logic rd_word_reg;
    logic rd_hole_reg;

    // shared enables and their global partners
    logic gain_en_reg;
    logic expo_en_reg;
    logic ae_en_reg;
    logic glob_gain_en_reg;
    logic glob_shut_en_reg;
    logic [2:0] en_vec;

    // per-word storage, index is sensor * 3 + kind
    logic mode_w [18];
    logic [11:0] value_w [18];

    // write decode
    logic wr_word_hit;
    logic wr_bank_hit;
    logic wr_mapped;
    logic [4:0] wr_idx;
    pse_kind_t wr_kind;

    // read decode
    logic rd_word_hit;
    logic rd_bank_hit;
    logic rd_mapped;
    logic [4:0] rd_idx;
    pse_ctrl_word_t rd_word;
    logic [31:0] rd_data;

    // a defined word: inside the bank, sensor below six, kind below three
    function automatic logic word_hit(input logic [15:0] a);
        word_hit = (a[15:8] == `PSE_BANK_HI) && (a[7:5] < `PSE_SENSORS)
            && (a[4:2] < `PSE_KINDS) && (a[1:0] == 2'h0);
    endfunction : word_hit

    function automatic logic bank_hit(input logic [15:0] a);
        bank_hit = (a[15:8] == `PSE_BANK_HI) && (a[7:0] < `PSE_BANK_END);
    endfunction : bank_hit

    function automatic logic [4:0] word_idx(input logic [15:0] a);
        word_idx = 5'({2'h0, a[7:5]} * 5'h3 + {3'h0, a[3:2]});
    endfunction : word_idx

    function automatic logic reg_hit(input logic [15:0] a);
        reg_hit = (a == `PSE_ADDR_BASE_PTR) || (a == `PSE_ADDR_GLOB_GAIN)
            || (a == `PSE_ADDR_GLOB_SHUT);
    endfunction : reg_hit

    assign en_vec = {ae_en_reg, expo_en_reg, gain_en_reg};

    // write side decode from the held address
    always_comb begin
        wr_word_hit = word_hit(awaddr_reg);
        wr_bank_hit = bank_hit(awaddr_reg);
        wr_mapped = wr_bank_hit || reg_hit(awaddr_reg);
        wr_idx = word_idx(awaddr_reg);
        wr_kind = pse_kind_t'(awaddr_reg[3:2]);
    end

    // commit once both halves are held and no response is pending
    assign wr_fire = aw_full_reg && w_full_reg && !bvalid;

    // address and data are taken independently, in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'h0;
            awready <= 1'h0;
            awaddr_reg <= 16'h0000;
        end else if (awvalid && awready) begin
            aw_full_reg <= 1'h1;
            awready <= 1'h0;
            awaddr_reg <= awaddr;
        end else if (bvalid && bready) begin
            aw_full_reg <= 1'h0;
        end else if (!aw_full_reg) begin
            awready <= 1'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_reg <= 1'h0;
            wready <= 1'h0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else if (wvalid && wready) begin
            w_full_reg <= 1'h1;
            wready <= 1'h0;
            wdata_reg <= wdata;
            wstrb_reg <= wstrb;
        end else if (bvalid && bready) begin
            w_full_reg <= 1'h0;
        end else if (!w_full_reg) begin
            wready <= 1'h1;
        end
    end

    // response rises on the commit edge and holds for bready
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'h0;
            bresp <= `PSE_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid <= 1'h1;
            bresp <= wr_mapped ? `PSE_RESP_OKAY : `PSE_RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'h0;
        end
    end

    // enable interlock; one write at a time, so no two sources collide
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gain_en_reg <= `PSE_RST_SUB_EN;
            expo_en_reg <= `PSE_RST_SUB_EN;
            ae_en_reg <= `PSE_RST_SUB_EN;
            glob_gain_en_reg <= `PSE_RST_GLOB_EN;
            glob_shut_en_reg <= `PSE_RST_GLOB_EN;
        end else if (wr_fire && wstrb_reg[0]) begin
            if (wr_word_hit) begin
                case (wr_kind)
                    pse_kind_gain: begin
                        gain_en_reg <= wdata_reg[6];
                        glob_gain_en_reg <= !wdata_reg[6];
                        ae_en_reg <= !wdata_reg[6];
                    end
                    pse_kind_expo: begin
                        expo_en_reg <= wdata_reg[6];
                        glob_shut_en_reg <= !wdata_reg[6];
                        ae_en_reg <= !wdata_reg[6];
                    end
                    pse_kind_ae: begin
                        ae_en_reg <= wdata_reg[6];
                        gain_en_reg <= !wdata_reg[6];
                        expo_en_reg <= !wdata_reg[6];
                        // globals follow too, so each pair stays inverse
                        glob_gain_en_reg <= wdata_reg[6];
                        glob_shut_en_reg <= wdata_reg[6];
                    end
                    default: begin
                        ae_en_reg <= ae_en_reg;
                    end
                endcase
            end else if (awaddr_reg == `PSE_ADDR_GLOB_GAIN) begin
                glob_gain_en_reg <= wdata_reg[6];
                gain_en_reg <= !wdata_reg[6];
            end else if (awaddr_reg == `PSE_ADDR_GLOB_SHUT) begin
                glob_shut_en_reg <= wdata_reg[6];
                expo_en_reg <= !wdata_reg[6];
            end
        end
    end

    // one word per sensor and kind; enable is the kind's shared bit
    genvar gi;
    generate
        for (gi = 0; gi < 18; gi++) begin : g_word
            pse_ctrl_word u_word (
                .aclk(aclk),
                .aresetn(aresetn),
                .wr_en(wr_fire && wr_word_hit && (wr_idx == 5'(gi))),
                .feat_en(en_vec[gi % 3]),
                .wdata(wdata_reg),
                .wstrb(wstrb_reg),
                .mode_reg(mode_w[gi]),
                .value_reg(value_w[gi])
            );
        end
    endgenerate

    // read side decode from the held address
    always_comb begin
        rd_word_hit = word_hit(araddr_reg);
        rd_bank_hit = bank_hit(araddr_reg);
        rd_mapped = rd_bank_hit || reg_hit(araddr_reg);
        rd_idx = word_idx(araddr_reg);
    end

    // read mux; reserved bits and holes are plain zeros
    always_comb begin
        rd_word = '0;
        rd_data = 32'h0000_0000;
        if (rd_word_hit) begin
            rd_word.present = `PSE_PRESENT;
            rd_word.enable = en_vec[araddr_reg[3:2]];
            rd_word.mode = mode_w[rd_idx];
            rd_word.value = value_w[rd_idx];
            rd_data = rd_word;
        end else if (araddr_reg == `PSE_ADDR_BASE_PTR) begin
            rd_data = `PSE_BANK_BASE;
        end else if (araddr_reg == `PSE_ADDR_GLOB_GAIN) begin
            rd_word.present = `PSE_PRESENT;
            rd_word.enable = glob_gain_en_reg;
            rd_data = rd_word;
        end else if (araddr_reg == `PSE_ADDR_GLOB_SHUT) begin
            rd_word.present = `PSE_PRESENT;
            rd_word.enable = glob_shut_en_reg;
            rd_data = rd_word;
        end
    end

    // read address is held until the data beat is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ar_full_reg <= 1'h0;
            arready <= 1'h0;
            araddr_reg <= 16'h0000;
        end else if (arvalid && arready) begin
            ar_full_reg <= 1'h1;
            arready <= 1'h0;
            araddr_reg <= araddr;
        end else if (rvalid && rready) begin
            ar_full_reg <= 1'h0;
        end else if (!ar_full_reg) begin
            arready <= 1'h1;
        end
    end

    // data is sampled one edge after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'h0;
            rdata <= 32'h0000_0000;
            rresp <= `PSE_RESP_OKAY;
            rd_word_reg <= 1'h0;
            rd_hole_reg <= 1'h0;
        end else if (ar_full_reg && !rvalid) begin
            rvalid <= 1'h1;
            rdata <= rd_data;
            rresp <= rd_mapped ? `PSE_RESP_OKAY : `PSE_RESP_SLVERR;
            rd_word_reg <= rd_word_hit;
            rd_hole_reg <= rd_bank_hit && !rd_word_hit;
        end else if (rready) begin
            rvalid <= 1'h0;
        end
    end

    // checks
    ptr_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (arvalid && arready && araddr == `PSE_ADDR_BASE_PTR)
        |=> ##1 (rvalid && rdata == `PSE_BANK_BASE))
        else $error("pointer read wrong");

    presence_bit_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (rvalid && rd_word_reg) |-> rdata[0] == 1'h1)
        else $error("presence bit not set");

    reserved_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (rvalid && rd_word_reg) |-> (rdata[19:8] == 12'h000 && rdata[5:1] == 5'h00))
        else $error("reserved bits not zero");

    hole_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (rvalid && rd_hole_reg) |-> (rdata == 32'h0000_0000 && rresp == `PSE_RESP_OKAY))
        else $error("bank hole not zero");

    disabled_freeze_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_fire && wr_word_hit && !en_vec[wr_kind])
        |=> ($stable(value_w[wr_idx]) && $stable(mode_w[wr_idx])))
        else $error("disabled word changed");

    auto_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_fire && wr_word_hit && mode_w[wr_idx]) |=> $stable(value_w[wr_idx]))
        else $error("auto value was written");

    value_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_fire && wr_word_hit && en_vec[wr_kind] && !mode_w[wr_idx]
            && wstrb_reg[3:2] == 2'h3)
        |=> value_w[wr_idx] == $past(wdata_reg[31:20]))
        else $error("manual value not stored");

    mode_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_fire && wr_word_hit && en_vec[wr_kind] && wstrb_reg[0])
        |=> mode_w[wr_idx] == $past(wdata_reg[7]))
        else $error("mode not stored");

    gain_link_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_fire && wr_word_hit && wr_kind == pse_kind_gain && wstrb_reg[0])
        |=> (gain_en_reg == $past(wdata_reg[6]) && glob_gain_en_reg == !gain_en_reg
            && ae_en_reg == !gain_en_reg))
        else $error("gain enable interlock broken");

    expo_link_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_fire && wr_word_hit && wr_kind == pse_kind_expo && wstrb_reg[0])
        |=> (expo_en_reg == $past(wdata_reg[6]) && glob_shut_en_reg == !expo_en_reg
            && ae_en_reg == !expo_en_reg))
        else $error("exposure enable interlock broken");

    ae_link_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_fire && wr_word_hit && wr_kind == pse_kind_ae && wstrb_reg[0])
        |=> (gain_en_reg == !ae_en_reg && expo_en_reg == !ae_en_reg
            && glob_gain_en_reg == ae_en_reg && glob_shut_en_reg == ae_en_reg
            && ae_en_reg == $past(wdata_reg[6])))
        else $error("auto-exposure interlock broken");

    glob_link_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_fire && wstrb_reg[0] && (awaddr_reg == `PSE_ADDR_GLOB_GAIN
            || awaddr_reg == `PSE_ADDR_GLOB_SHUT))
        |=> (glob_gain_en_reg != gain_en_reg) && (glob_shut_en_reg != expo_en_reg))
        else $error("global enable interlock broken");

    write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire |=> bvalid)
        else $error("write response missing");

endmodule : pse_regs
`default_nettype wire

//--- pse_defines.svh
// How it works
// - read-only pointer gives the bank base offset
// - bit 0 reads one: feature present
// - bit 6 enables; when clear, word frozen
// - one gain enable shared by all sensors
// - gain enable and global gain enable inverse
// - gain enable write sets auto-exposure inverse
// - one exposure-time enable shared by all sensors
// - exposure enable and global shutter enable inverse
// - exposure enable write sets auto-exposure inverse
// - auto-exposure enable write inverts gain, exposure enables
// - bit 7 holds mode: 0 manual, 1 auto
// - gain word bits 20-31 hold gain value
// - exposure word bits 20-31 hold shutter value
// - auto-exposure word bits 20-31 hold its value
// - value writes ignored while in auto mode
// - sensor n at base plus n times 20h
`ifndef PSE_DEFINES_SVH
`define PSE_DEFINES_SVH

// register byte addresses
`define PSE_ADDR_BASE_PTR 16'h1E94
`define PSE_ADDR_GLOB_SHUT 16'h081C
`define PSE_ADDR_GLOB_GAIN 16'h0820
// bank base, aligned to 256 bytes so decode is a compare
`define PSE_BANK_BASE 32'h0000_2000
`define PSE_BANK_HI 8'h20
`define PSE_BANK_END 8'hC0
`define PSE_SENSORS 3'h6
`define PSE_WORDS 5'h12
`define PSE_KINDS 3'h3

// reset values
`define PSE_RST_SUB_EN 1'h0
`define PSE_RST_GLOB_EN 1'h1
`define PSE_RST_MODE 1'h0
`define PSE_RST_VALUE 12'h000
`define PSE_PRESENT 1'h1

// axi responses
`define PSE_RESP_OKAY 2'h0
`define PSE_RESP_SLVERR 2'h2

`endif

//--- pse_pkg.sv
package pse_pkg;

    // kind of word inside one sensor's 20h slot
    typedef enum logic [1:0] {
        pse_kind_gain = 2'h0,
        pse_kind_expo = 2'h1,
        pse_kind_ae = 2'h2
    } pse_kind_t;

    // layout of every per-sensor control word
    typedef struct packed {
        logic [11:0] value;
        logic [11:0] rsvd_hi;
        logic mode;
        logic enable;
        logic [4:0] rsvd_lo;
        logic present;
    } pse_ctrl_word_t;

endpackage : pse_pkg

//--- pse_ctrl_word.sv
`timescale 1ns/10ps
`default_nettype none
`include "pse_defines.svh"
module pse_ctrl_word
    import pse_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic wr_en,
    input wire logic feat_en,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic mode_reg,
    output logic [11:0] value_reg
);
    logic [11:0] value_next;

    // byte lanes 2 and 3 carry the value field
    always_comb begin
        value_next[3:0] = wstrb[2] ? wdata[23:20] : value_reg[3:0];
        value_next[11:4] = wstrb[3] ? wdata[31:24] : value_reg[11:4];
    end

    // mode only moves while the feature is on
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_reg <= `PSE_RST_MODE;
        end else if (wr_en && feat_en && wstrb[0]) begin
            mode_reg <= wdata[7];
        end
    end

    // old mode decides, so a write switching to auto still lands
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            value_reg <= `PSE_RST_VALUE;
        end else if (wr_en && feat_en && !mode_reg) begin
            value_reg <= value_next;
        end
    end

endmodule : pse_ctrl_word
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "pse_defines.svh"
module tb_top
    import pse_pkg::*;
;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [15:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    int error_cnt = 0;
    int check_count = 0;

    pse_regs dut_u (
        .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp)
    );

    // 10 mhz clock
    initial begin
        aclk = 1'h0;
        forever #50 aclk = ~aclk;
    end

    // sensor word address: 20h slot per sensor, 4 bytes per kind
    function automatic logic [15:0] waddr(input int n, input int k);
        return 16'(`PSE_BANK_BASE) + 16'(n * 32) + 16'(k * 4);
    endfunction : waddr

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic test_done();
        $display("errors %0d, checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    // address and data offered together, each dropped at its own handshake
    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        logic aw_done, w_done;
        aw_done = 1'h0;
        w_done = 1'h0;
        @(posedge aclk);
        awvalid <= 1'h1;
        awaddr <= a;
        wvalid <= 1'h1;
        wdata <= d;
        wstrb <= s;
        bready <= 1'h1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                awvalid <= 1'h0;
                aw_done = 1'h1;
            end
            if (wvalid && wready) begin
                wvalid <= 1'h0;
                w_done = 1'h1;
            end
        end
        // bready held until the response is seen
        do @(posedge aclk); while (bvalid !== 1'h1);
        bready <= 1'h0;
        chk({30'h0, bresp}, {30'h0, er}, "write response");
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        @(posedge aclk);
        arvalid <= 1'h1;
        araddr <= a;
        rready <= 1'h1;
        do @(posedge aclk); while (arready !== 1'h1);
        arvalid <= 1'h0;
        do @(posedge aclk); while (rvalid !== 1'h1);
        d = rdata;
        r = rresp;
        rready <= 1'h0;
        chk(d, ed, "read data");
        chk({30'h0, r}, {30'h0, er}, "read response");
    endtask : rd

    task automatic t_reset_values();
        rd(`PSE_ADDR_BASE_PTR, `PSE_BANK_BASE, `PSE_RESP_OKAY);
        for (int n = 0; n < 6; n++) begin
            for (int k = 0; k < 3; k++) begin
                rd(waddr(n, k), 32'h0000_0001, `PSE_RESP_OKAY);
            end
        end
        rd(`PSE_ADDR_GLOB_GAIN, 32'h0000_0041, `PSE_RESP_OKAY);
        rd(`PSE_ADDR_GLOB_SHUT, 32'h0000_0041, `PSE_RESP_OKAY);
    endtask : t_reset_values

    // disabled word: value lanes frozen; byte lane 0, which holds the mode, is not strobed
    task automatic t_frozen();
        wr(waddr(0, 0), 32'hABC0_0080, 4'hE, `PSE_RESP_OKAY);
        rd(waddr(0, 0), 32'h0000_0001, `PSE_RESP_OKAY);
    endtask : t_frozen

    task automatic t_gain_interlock();
        wr(waddr(2, 2), 32'h0000_0041, 4'hF, `PSE_RESP_OKAY);
        rd(waddr(0, 2), 32'h0000_0041, `PSE_RESP_OKAY);
        wr(waddr(3, 0), 32'h0000_0041, 4'hF, `PSE_RESP_OKAY);
        for (int n = 0; n < 6; n++) begin
            rd(waddr(n, 0), 32'h0000_0041, `PSE_RESP_OKAY);
        end
        rd(`PSE_ADDR_GLOB_GAIN, 32'h0000_0001, `PSE_RESP_OKAY);
        rd(waddr(5, 2), 32'h0000_0001, `PSE_RESP_OKAY);
        wr(`PSE_ADDR_GLOB_GAIN, 32'h0000_0041, 4'hF, `PSE_RESP_OKAY);
        rd(waddr(1, 0), 32'h0000_0001, `PSE_RESP_OKAY);
        wr(waddr(0, 0), 32'h0000_0041, 4'hF, `PSE_RESP_OKAY);
    endtask : t_gain_interlock

    // manual value, then auto mode locks the value; reserved bits stay zero
    task automatic t_mode_value();
        wr(waddr(1, 0), 32'hABC0_0041, 4'hF, `PSE_RESP_OKAY);
        rd(waddr(1, 0), 32'hABC0_0041, `PSE_RESP_OKAY);
        rd(waddr(0, 0), 32'h0000_0041, `PSE_RESP_OKAY);
        wr(waddr(1, 0), 32'h1230_00C1, 4'hF, `PSE_RESP_OKAY);
        rd(waddr(1, 0), 32'h1230_00C1, `PSE_RESP_OKAY);
        wr(waddr(1, 0), 32'h456F_FFFF, 4'hF, `PSE_RESP_OKAY);
        rd(waddr(1, 0), 32'h1230_00C1, `PSE_RESP_OKAY);
    endtask : t_mode_value

    task automatic t_expo_interlock();
        wr(waddr(0, 2), 32'h0000_0041, 4'hF, `PSE_RESP_OKAY);
        rd(waddr(4, 0), 32'h0000_0001, `PSE_RESP_OKAY);
        rd(`PSE_ADDR_GLOB_GAIN, 32'h0000_0041, `PSE_RESP_OKAY);
        wr(waddr(4, 1), 32'h0000_0041, 4'hF, `PSE_RESP_OKAY);
        rd(waddr(0, 1), 32'h0000_0041, `PSE_RESP_OKAY);
        rd(waddr(5, 1), 32'h0000_0041, `PSE_RESP_OKAY);
        rd(`PSE_ADDR_GLOB_SHUT, 32'h0000_0001, `PSE_RESP_OKAY);
        rd(waddr(3, 2), 32'h0000_0001, `PSE_RESP_OKAY);
        wr(waddr(2, 1), 32'h7FF0_0041, 4'hF, `PSE_RESP_OKAY);
        rd(waddr(2, 1), 32'h7FF0_0041, `PSE_RESP_OKAY);
        wr(`PSE_ADDR_GLOB_SHUT, 32'h0000_0041, 4'hF, `PSE_RESP_OKAY);
        rd(waddr(5, 1), 32'h0000_0001, `PSE_RESP_OKAY);
        wr(waddr(1, 2), 32'h0000_0041, 4'hF, `PSE_RESP_OKAY);
        wr(waddr(1, 2), 32'h5A50_0041, 4'hF, `PSE_RESP_OKAY);
        rd(waddr(1, 2), 32'h5A50_0041, `PSE_RESP_OKAY);
    endtask : t_expo_interlock

    // holes, unmapped space and the read-only pointer
    task automatic t_holes();
        wr(16'h200C, 32'hFFFF_FFFF, 4'hF, `PSE_RESP_OKAY);
        rd(16'h200C, 32'h0000_0000, `PSE_RESP_OKAY);
        rd(waddr(1, 2), 32'h5A50_0041, `PSE_RESP_OKAY);
        rd(16'h0100, 32'h0000_0000, `PSE_RESP_SLVERR);
        wr(16'h0100, 32'hFFFF_FFFF, 4'hF, `PSE_RESP_SLVERR);
        wr(`PSE_ADDR_BASE_PTR, 32'h0000_1234, 4'hF, `PSE_RESP_OKAY);
        rd(`PSE_ADDR_BASE_PTR, `PSE_BANK_BASE, `PSE_RESP_OKAY);
    endtask : t_holes

    // watchdog: far beyond the few hundred cycles of the run
    initial begin
        #(100 * 30000);
        error_cnt++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        test_done();
    end

    initial begin
        aresetn = 1'h0;
        awvalid = 1'h0;
        awaddr = 16'h0000;
        wvalid = 1'h0;
        wdata = 32'h0000_0000;
        wstrb = 4'h0;
        bready = 1'h0;
        arvalid = 1'h0;
        araddr = 16'h0000;
        rready = 1'h0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (2) @(posedge aclk);
        t_reset_values();
        t_frozen();
        t_gain_interlock();
        t_mode_value();
        t_expo_interlock();
        t_holes();
        repeat (4) @(posedge aclk);
        test_done();
    end
endmodule : tb_top
`default_nettype wire
